//--- core/dtr_interval.sv
`timescale 1ns/1ps
module dtr_interval
(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // Timer side of the carrier
   dtr_tmr_if.tmr    tmr
);
   typedef struct packed {
      logic [28:0] elapsed;
      logic        running;
      logic        done;
   } dtr_ivl_s;

   dtr_ivl_s r;
   dtr_ivl_s r_nxt;

   always_comb
   begin
      r_nxt      = r;
      r_nxt.done = 1'b0;
      if (tmr.clear)
      begin
         r_nxt.elapsed = 29'h0;
         r_nxt.running = 1'b0;
      end
      else if (tmr.start)
      begin
         r_nxt.elapsed = 29'h0;
         r_nxt.running = 1'b1;
      end
      else if (r.running && tmr.tick)
      begin
         // Advance once per time-base tick
         if (r.elapsed + 29'h1 >= tmr.preset)
         begin
            r_nxt.elapsed = 29'h0;
            r_nxt.running = 1'b0;
            r_nxt.done    = 1'b1;
         end
         else
            r_nxt.elapsed = r.elapsed + 29'h1;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         r <= '0;
      else
         r <= r_nxt;
   end

   assign tmr.elapsed = r.elapsed;
   assign tmr.done    = r.done;
endmodule

//--- core/dtr_pkg.sv
package dtr_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TICK_TIME_MS  = 10;
   localparam int unsigned TICK_CYC      =
      TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned TICK_CNT_W    = 21;
   localparam int unsigned PRESET_W      = 29;

   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_ON_TIME  = 8'h04;
   localparam logic [7:0]  OFS_OFF_TIME = 8'h08;
   localparam logic [7:0]  OFS_STATUS   = 8'h0C;
   localparam logic [7:0]  OFS_RUN_VAL  = 8'h10;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_EN_BIT   = 2;
   localparam int unsigned CS_LSB        = 0;
   localparam int unsigned SEC_LSB       = 8;
   localparam int unsigned MIN_LSB       = 16;
   localparam int unsigned HR_LSB        = 22;
   localparam int unsigned STAT_Q_BIT    = 0;
   localparam int unsigned STAT_RUN_BIT  = 1;
   localparam int unsigned STAT_TRG_BIT  = 2;
   localparam int unsigned STAT_ONW_BIT  = 3;

   // -------------------------------------------------------------
   // Reset values and field limits
   // -------------------------------------------------------------
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] TIME_RST     = 32'h0000_0001;
   localparam int unsigned MAX_CS       = 99;
   localparam int unsigned MAX_SEC      = 59;
   localparam int unsigned MAX_MIN      = 59;
   localparam int unsigned MAX_HR       = 999;
   localparam int unsigned TICKS_SEC    = 100;
   localparam int unsigned TICKS_MIN    = 6000;
   localparam int unsigned TICKS_HR     = 360000;

   typedef enum logic [1:0] {
      MODE_ON_DELAY     = 2'b00,
      MODE_OFF_DELAY    = 2'b01,
      MODE_ON_OFF_DELAY = 2'b10
   } dtr_mode_e;

   // Preset word to 10 ms ticks; fields saturate, zero reads as one
   function automatic logic [28:0] preset_ticks(input logic [31:0] w);
      logic [28:0] cs;
      logic [28:0] sec;
      logic [28:0] mn;
      logic [28:0] hr;
      logic [28:0] sum;
      cs  = 29'(w[CS_LSB +: 7]);
      sec = 29'(w[SEC_LSB +: 6]);
      mn  = 29'(w[MIN_LSB +: 6]);
      hr  = 29'(w[HR_LSB +: 10]);
      if (cs > 29'(MAX_CS)) cs = 29'(MAX_CS);
      if (sec > 29'(MAX_SEC)) sec = 29'(MAX_SEC);
      if (mn > 29'(MAX_MIN)) mn = 29'(MAX_MIN);
      if (hr > 29'(MAX_HR)) hr = 29'(MAX_HR);
      sum = hr * 29'(TICKS_HR) + mn * 29'(TICKS_MIN)
            + sec * 29'(TICKS_SEC) + cs;
      if (sum == 29'h0) sum = 29'h1;
      return sum;
   endfunction

endpackage

//--- core/dtr_tick_gen.sv
`timescale 1ns/1ps
module dtr_tick_gen
#(
   parameter int unsigned TICK_CYCLES = dtr_pkg::TICK_CYC
)
(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // Control and tick
   input  wire logic run_in,
   output logic      tick_out
);
   typedef struct packed {
      logic [20:0] cnt;
      logic        tick;
   } dtr_tick_s;

   dtr_tick_s r;
   dtr_tick_s r_nxt;

   always_comb
   begin
      r_nxt      = r;
      r_nxt.tick = 1'b0;
      if (!run_in)
         r_nxt.cnt = 21'h0;
      else if (r.cnt == 21'(TICK_CYCLES - 1))
      begin
         r_nxt.cnt  = 21'h0;
         r_nxt.tick = 1'b1;
      end
      else
         r_nxt.cnt = r.cnt + 21'h1;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         r <= '0;
      else
         r <= r_nxt;
   end

   assign tick_out = r.tick;
endmodule

//--- core/dtr_tmr_if.sv
`timescale 1ns/1ps
interface dtr_tmr_if;
   logic        tick;
   logic        start;
   logic        clear;
   logic [28:0] preset;
   logic [28:0] elapsed;
   logic        done;

   modport ctl
   (
      output tick,
      output start,
      output clear,
      output preset,
      input  elapsed,
      input  done
   );

   modport tmr
   (
      input  tick,
      input  start,
      input  clear,
      input  preset,
      output elapsed,
      output done
   );
endinterface

//--- core/dtr_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Overview of operation
// - On-delay: trigger rise starts interval counter
// - On-delay: output high after full interval
// - On-delay: early trigger drop clears counter
// - On-delay: output low while trigger low
// - On-delay: reset clears counter, output low
// - Elapsed value published to running value register
// - Preset held as h:m:s:hundredths, 10 ms steps
// - Off-delay: output high while trigger high
// - Off-delay: fall starts counter, expiry drops output
// - Off-delay: every further fall restarts counter
// - Off-delay: reset clears counter, output low
// - On/off: rise starts on time, expiry sets
// - On/off: early drop clears on time only
// - On/off: fall starts off time, expiry clears
// - On/off: early rise clears off time
// - On/off: reset clears both, output low
// ---------------------------------------------------------------------
module dtr_top
#(
   parameter int unsigned TICK_CYCLES = dtr_pkg::TICK_CYC
)
(
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Register bus
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Function block inputs
   input  wire logic        trg_in,
   input  wire logic        blk_rst_in,
   // Function block outputs
   output logic             q_out,
   output logic [31:0]      running_value_out
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_ON_WAIT  = 2'b01,
      ST_OFF_WAIT = 2'b10
   } dtr_state_e;

   typedef struct packed {
      dtr_pkg::dtr_mode_e on_off_mode;
      logic               en;
      logic [31:0]        on_delay_time;
      logic [31:0]        off_delay_time;
      dtr_state_e         st;
      logic               q;
      logic               trg_prev;
      logic               start;
      logic               clear;
      logic [31:0]        running_value_register;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
      logic               wr_ok;
   } dtr_top_s;

   dtr_top_s r;
   dtr_top_s r_nxt;

   dtr_tmr_if tif ();

   logic tick;

   // ------------------------------------------------------------------
   // Time base and interval counter
   // ------------------------------------------------------------------
   dtr_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .run_in     (r.en),
      .tick_out   (tick)
   );

   dtr_interval u_ivl (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .tmr        (tif.tmr)
   );

   assign tif.tick  = tick;
   assign tif.start = r.start;
   assign tif.clear = r.clear;

   // The off time is used only while an off interval runs
   assign tif.preset = (r.st == ST_OFF_WAIT)
                     ? dtr_pkg::preset_ticks(r.off_delay_time)
                     : dtr_pkg::preset_ticks(r.on_delay_time);

   // ------------------------------------------------------------------
   // Bus helpers
   // ------------------------------------------------------------------
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == dtr_pkg::OFS_CTRL)     ||
                   (a == dtr_pkg::OFS_ON_TIME)  ||
                   (a == dtr_pkg::OFS_OFF_TIME) ||
                   (a == dtr_pkg::OFS_STATUS)   ||
                   (a == dtr_pkg::OFS_RUN_VAL);
   endfunction

   function automatic logic addr_is_cfg(input logic [7:0] a);
      addr_is_cfg = (a == dtr_pkg::OFS_CTRL)    ||
                    (a == dtr_pkg::OFS_ON_TIME) ||
                    (a == dtr_pkg::OFS_OFF_TIME);
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      logic        rise;
      logic        fall;
      logic        busy;
      logic [31:0] rd;
      rise = 1'b0;
      fall = 1'b0;
      busy = 1'b0;
      rd   = 32'h0;

      r_nxt         = r;
      r_nxt.start   = 1'b0;
      r_nxt.clear   = 1'b0;
      r_nxt.pready  = 1'b0;
      r_nxt.pslverr = 1'b0;

      // ---------------------------------------------------------------
      // Timer behaviour
      // ---------------------------------------------------------------
      if (blk_rst_in || !r.en)
      begin
         // Reset input wins over any trigger activity
         r_nxt.st    = ST_IDLE;
         r_nxt.q     = 1'b0;
         r_nxt.clear = 1'b1;
         if (tick)
            r_nxt.trg_prev = trg_in;
      end
      else if (tick)
      begin
         rise           = trg_in && !r.trg_prev;
         fall           = !trg_in && r.trg_prev;
         r_nxt.trg_prev = trg_in;
         unique case (r.on_off_mode)
            dtr_pkg::MODE_OFF_DELAY:
            begin
               if (trg_in)
               begin
                  r_nxt.q = 1'b1;
                  if (r.st != ST_IDLE)
                  begin
                     r_nxt.clear = 1'b1;
                     r_nxt.st    = ST_IDLE;
                  end
               end
               else if (fall)
               begin
                  // Each fall restarts from zero, output stays high
                  r_nxt.start = 1'b1;
                  r_nxt.st    = ST_OFF_WAIT;
               end
            end
            dtr_pkg::MODE_ON_OFF_DELAY:
            begin
               if (rise)
               begin
                  // Drops any running off time, output unchanged
                  r_nxt.start = 1'b1;
                  r_nxt.st    = ST_ON_WAIT;
               end
               else if (fall)
               begin
                  // Drops any running on time, output unchanged
                  r_nxt.start = 1'b1;
                  r_nxt.st    = ST_OFF_WAIT;
               end
            end
            default:
            begin
               if (!trg_in)
                  r_nxt.q = 1'b0;
               if (rise)
               begin
                  r_nxt.start = 1'b1;
                  r_nxt.st    = ST_ON_WAIT;
               end
               else if (!trg_in && r.st == ST_ON_WAIT)
               begin
                  r_nxt.clear = 1'b1;
                  r_nxt.st    = ST_IDLE;
               end
            end
         endcase
      end
      // A done pulse seen with a fresh start is ignored, so it cannot end the new interval
      else if (tif.done && !r.start)
      begin
         unique case (r.st)
            ST_ON_WAIT:
            begin
               r_nxt.q  = 1'b1;
               r_nxt.st = ST_IDLE;
            end
            ST_OFF_WAIT:
            begin
               r_nxt.q  = 1'b0;
               r_nxt.st = ST_IDLE;
            end
            ST_IDLE:
            begin
               r_nxt.st = ST_IDLE;
            end
            default:
            begin
               r_nxt.st = ST_IDLE;
            end
         endcase
      end

      r_nxt.running_value_register = 32'(tif.elapsed);

      // ---------------------------------------------------------------
      // Register bus
      // ---------------------------------------------------------------
      busy = (r.st != ST_IDLE);
      unique case (paddr_in)
         dtr_pkg::OFS_CTRL:
         begin
            rd[dtr_pkg::CTRL_MODE_LSB +: 2] = r.on_off_mode;
            rd[dtr_pkg::CTRL_EN_BIT]        = r.en;
         end
         dtr_pkg::OFS_ON_TIME:
            rd = r.on_delay_time;
         dtr_pkg::OFS_OFF_TIME:
            rd = r.off_delay_time;
         dtr_pkg::OFS_STATUS:
         begin
            rd[dtr_pkg::STAT_Q_BIT]   = r.q;
            rd[dtr_pkg::STAT_RUN_BIT] = busy;
            rd[dtr_pkg::STAT_TRG_BIT] = r.trg_prev;
            rd[dtr_pkg::STAT_ONW_BIT] = (r.st == ST_ON_WAIT);
         end
         dtr_pkg::OFS_RUN_VAL:
            rd = r.running_value_register;
         default:
            rd = 32'h0;
      endcase

      // Access phase: answer one cycle after penable rises
      if (psel_in && penable_in && !r.pready)
      begin
         r_nxt.pready = 1'b1;
         r_nxt.prdata = pwrite_in ? 32'h0 : rd;
         r_nxt.wr_ok  = pwrite_in && addr_is_cfg(paddr_in) && !busy;
         // Unmapped address, or config write while timing
         r_nxt.pslverr = !addr_known(paddr_in) ||
                         (pwrite_in && addr_is_cfg(paddr_in) && busy);
      end

      // Write commits on the edge that completes the transfer
      if (psel_in && penable_in && r.pready && pwrite_in)
      begin
         if (paddr_in == dtr_pkg::OFS_CTRL)
            r_nxt.en = pwdata_in[dtr_pkg::CTRL_EN_BIT];
         if (r.wr_ok)
         begin
            unique case (paddr_in)
               dtr_pkg::OFS_CTRL:
               begin
                  if (pwdata_in[dtr_pkg::CTRL_MODE_LSB +: 2] == 2'b11)
                     r_nxt.on_off_mode = dtr_pkg::MODE_ON_DELAY;
                  else
                     r_nxt.on_off_mode = dtr_pkg::dtr_mode_e'(
                        pwdata_in[dtr_pkg::CTRL_MODE_LSB +: 2]);
               end
               dtr_pkg::OFS_ON_TIME:
                  r_nxt.on_delay_time = pwdata_in;
               dtr_pkg::OFS_OFF_TIME:
                  r_nxt.off_delay_time = pwdata_in;
               default:
                  r_nxt.wr_ok = 1'b0;
            endcase
         end
         r_nxt.wr_ok = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         r                        <= '0;
         r.on_off_mode            <= dtr_pkg::MODE_ON_DELAY;
         r.en                     <= dtr_pkg::CTRL_RST[dtr_pkg::CTRL_EN_BIT];
         r.on_delay_time          <= dtr_pkg::TIME_RST;
         r.off_delay_time         <= dtr_pkg::TIME_RST;
         r.st                     <= ST_IDLE;
      end
      else
         r <= r_nxt;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign prdata_out        = r.prdata;
   assign pready_out        = r.pready;
   assign pslverr_out       = r.pslverr;
   assign q_out             = r.q;
   assign running_value_out = r.running_value_register;

endmodule

//--- test/dtr_chk.sv
`timescale 1ns/1ps
module dtr_chk
(
   // Clock and reset
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   // Register bus
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Function block
   input wire logic        blk_rst_in,
   input wire logic        q_out,
   input wire logic [31:0] running_value_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   property p_rdy_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse)
      else $error("pready longer than one cycle");

   property p_rdy_wait;
      psel_in && penable_in && !pready_out |=> pready_out;
   endproperty
   a_rdy_wait: assert property (p_rdy_wait)
      else $error("access not answered after one wait");

   property p_err_rdy;
      pslverr_out |-> pready_out;
   endproperty
   a_err_rdy: assert property (p_err_rdy)
      else $error("pslverr outside answer cycle");

   property p_unmapped;
      pready_out && (paddr_in > 8'h10 || paddr_in[1:0] != 2'b00)
         |-> pslverr_out && prdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access without error");

   property p_rst_q;
      blk_rst_in |=> !q_out;
   endproperty
   a_rst_q: assert property (p_rst_q)
      else $error("q not low after block reset");

   property p_rst_val;
      blk_rst_in [*4] |-> running_value_out == 32'h0;
   endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("running value kept under block reset");

   property p_q_rise;
      $rose(q_out) |-> !$past(blk_rst_in);
   endproperty
   a_q_rise: assert property (p_q_rise)
      else $error("q rose during block reset");

   property p_run_step;
      $changed(running_value_out) |-> running_value_out == 32'h0
         || running_value_out == $past(running_value_out) + 32'h1;
   endproperty
   a_run_step: assert property (p_run_step)
      else $error("running value skipped a step");
endmodule

bind dtr_top dtr_chk u_chk
(
   .sys_clk_in        (sys_clk_in),
   .rst_in            (rst_in),
   .psel_in           (psel_in),
   .penable_in        (penable_in),
   .paddr_in          (paddr_in),
   .prdata_out        (prdata_out),
   .pready_out        (pready_out),
   .pslverr_out       (pslverr_out),
   .blk_rst_in        (blk_rst_in),
   .q_out             (q_out),
   .running_value_out (running_value_out)
);

//--- test/dtr_src.sv
`timescale 1ns/1ps
module dtr_src
(
   // Clock
   input  wire logic sys_clk_in,
   // Requested levels
   input  wire logic trg_req_in,
   input  wire logic rst_req_in,
   // Levels seen by the block
   output logic      trg_out     = 1'b0,
   output logic      blk_rst_out = 1'b0
);
   // Upstream gate outputs are registered, changing once per clock
   always_ff @(posedge sys_clk_in)
   begin
      trg_out     <= trg_req_in;
      blk_rst_out <= rst_req_in;
   end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int TC = 10;
   logic        sys_clk_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [7:0]  paddr      = 8'h00;
   logic [31:0] pwdata     = 32'h0;
   logic        trg_req    = 1'b0;
   logic        rst_req    = 1'b0;
   logic [31:0] seed       = 32'h92C80965;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        trg;
   logic        blk_rst;
   logic        q;
   logic [31:0] run_val;
   logic [31:0] rd;
   logic        err;
   logic [31:0] pre[4];
   int          n_mismatch = 0;
   int          checked    = 0;
   int          n1;
   int          n2;

   always #4 sys_clk_in = ~sys_clk_in;

   dtr_top #(.TICK_CYCLES(TC)) DUT
   (
      .sys_clk_in        (sys_clk_in),
      .rst_in            (rst_in),
      .psel_in           (psel),
      .penable_in        (penable),
      .pwrite_in         (pwrite),
      .paddr_in          (paddr),
      .pwdata_in         (pwdata),
      .prdata_out        (prdata),
      .pready_out        (pready),
      .pslverr_out       (pslverr),
      .trg_in            (trg),
      .blk_rst_in        (blk_rst),
      .q_out             (q),
      .running_value_out (run_val)
   );

   dtr_src u_src
   (
      .sys_clk_in  (sys_clk_in),
      .trg_req_in  (trg_req),
      .rst_req_in  (rst_req),
      .trg_out     (trg),
      .blk_rst_out (blk_rst)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   // Preset word to ticks from hundredths and seconds only; both saturate, zero counts as one
   function automatic int ticks(input logic [31:0] w);
      int t;
      t = (w[6:0] > 7'h63) ? 99 : int'(w[6:0]);
      t = t + 100 * ((w[13:8] > 6'h3B) ? 59 : int'(w[13:8]));
      return (t == 0) ? 1 : t;
   endfunction

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge sys_clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk_in);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge sys_clk_in);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 20)
      begin
         n_mismatch++;
         $display("MISMATCH pready expected 1 seen timeout");
         complete_run();
      end
   endtask

   task automatic drv(input logic t, input logic r);
      @(posedge sys_clk_in);
      trg_req <= t;
      rst_req <= r;
   endtask

   task automatic wait_q(input logic v, input int lo, input int hi);
      int i;
      i = 0;
      while (q !== v && i <= hi)
      begin
         @(posedge sys_clk_in);
         i++;
      end
      if (i > hi)
      begin
         n_mismatch++;
         $display("MISMATCH q expected %b seen timeout", v);
         complete_run();
      end
      chk("q delay in window", 32'h1, {31'h0, i >= lo});
   endtask

   task automatic wait_n(input logic v, input int n);
      wait_q(v, n * TC, (n + 1) * TC + 6);
   endtask

   task automatic hold_q(input logic v, input int n);
      int bad;
      bad = 0;
      repeat (n)
      begin
         @(posedge sys_clk_in);
         if (q !== v)
            bad++;
      end
      chk("q held", 32'h0, 32'(bad));
   endtask

   task automatic cfg(input dtr_pkg::dtr_mode_e m, input logic [31:0] on_w,
                      input logic [31:0] off_w, input logic t);
      // Let one tick sample a low trigger so a high start reads as a rise
      drv(1'b0, 1'b0);
      repeat (TC + 2) @(posedge sys_clk_in);
      apb(1'b1, 8'h00, 32'h0);
      drv(t, 1'b0);
      apb(1'b1, 8'h04, on_w);
      apb(1'b1, 8'h08, off_w);
      apb(1'b1, 8'h00, {29'h0, 1'b1, m});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("on time reset", 32'h1, rd);
      apb(1'b0, 8'h08, 32'h0);
      chk("off time reset", 32'h1, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("run value reset", 32'h0, rd);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped read error", 32'h1, {31'h0, err});
      seed = xs(seed);
      apb(1'b1, 8'h40, seed);
      chk("unmapped write error", 32'h1, {31'h0, err});
      $display("test registers done");

      seed = xs(seed);
      pre = '{32'h0, 32'h7F, 32'h100, 32'(2 + int'(seed % 32'h5))};
      foreach (pre[k])
      begin
         cfg(dtr_pkg::MODE_ON_DELAY, pre[k], 32'h1, 1'b1);
         wait_n(1'b1, ticks(pre[k]));
      end
      $display("test presets done");

      seed = xs(seed);
      n1 = 2 + int'(seed % 32'h5);
      cfg(dtr_pkg::MODE_ON_DELAY, 32'(n1), 32'h1, 1'b1);
      repeat (2 * TC) @(posedge sys_clk_in);
      apb(1'b0, 8'h10, 32'h0);
      chk("run value counting", 32'h1, {31'h0, rd != 0 && rd < n1});
      chk("run value out", 32'h1, run_val);
      apb(1'b1, 8'h04, 32'h3);
      chk("locked preset error", 32'h1, {31'h0, err});
      apb(1'b0, 8'h04, 32'h0);
      chk("locked preset kept", 32'(n1), rd);
      wait_q(1'b1, (n1 - 2) * TC, (n1 - 1) * TC);
      drv(1'b0, 1'b0);
      wait_q(1'b0, 0, TC + 4);
      drv(1'b1, 1'b0);
      repeat ((n1 - 1) * TC) @(posedge sys_clk_in);
      drv(1'b0, 1'b0);
      hold_q(1'b0, (n1 + 2) * TC);
      drv(1'b1, 1'b0);
      wait_n(1'b1, n1);
      drv(1'b1, 1'b1);
      wait_q(1'b0, 0, 3);
      hold_q(1'b0, (n1 + 2) * TC);
      drv(1'b0, 1'b0);
      $display("test on delay done");

      cfg(dtr_pkg::MODE_OFF_DELAY, 32'h1, 32'(n1), 1'b0);
      drv(1'b1, 1'b0);
      wait_q(1'b1, 0, TC + 5);
      drv(1'b0, 1'b0);
      wait_n(1'b0, n1);
      drv(1'b1, 1'b0);
      wait_q(1'b1, 0, TC + 5);
      drv(1'b0, 1'b0);
      repeat (TC * n1 / 2) @(posedge sys_clk_in);
      drv(1'b1, 1'b0);
      repeat (2 * TC) @(posedge sys_clk_in);
      drv(1'b0, 1'b0);
      wait_n(1'b0, n1);
      drv(1'b1, 1'b0);
      wait_q(1'b1, 0, TC + 5);
      drv(1'b0, 1'b0);
      repeat (TC) @(posedge sys_clk_in);
      drv(1'b0, 1'b1);
      wait_q(1'b0, 0, 3);
      drv(1'b0, 1'b0);
      $display("test off delay done");

      seed = xs(seed);
      n2 = 2 + int'(seed % 32'h5);
      cfg(dtr_pkg::MODE_ON_OFF_DELAY, 32'(n1), 32'(n2), 1'b0);
      drv(1'b1, 1'b0);
      wait_n(1'b1, n1);
      drv(1'b0, 1'b0);
      wait_n(1'b0, n2);
      drv(1'b1, 1'b0);
      repeat ((n1 - 1) * TC) @(posedge sys_clk_in);
      drv(1'b0, 1'b0);
      hold_q(1'b0, (n1 + 2) * TC);
      drv(1'b1, 1'b0);
      wait_n(1'b1, n1);
      drv(1'b0, 1'b0);
      repeat ((n2 - 1) * TC) @(posedge sys_clk_in);
      drv(1'b1, 1'b0);
      hold_q(1'b1, (n2 + 2) * TC);
      drv(1'b1, 1'b1);
      wait_q(1'b0, 0, 3);
      drv(1'b0, 1'b0);
      $display("test on off delay done");
      complete_run();
   end
endmodule
